// ---- logic/plps_regs.vh ----
// register offsets, field layouts, reset values and timing constants
`ifndef PLPS_REGS_VH
`define PLPS_REGS_VH

// register indices; byte address is four times the index
`define PLPS_IDX_BLINK 16'h001D
`define PLPS_IDX_STATUS 16'h001F
`define PLPS_IDX_CAP 16'h8000
`define PLPS_IDX_GAP 16'h0100

`define PLPS_BLINK_RESET 16'h1855
`define PLPS_STATUS_RESET 16'h03FC
`define PLPS_CAP_VALUE 16'h0006
`define PLPS_GAP_RESET 8'h00

`define PLPS_SEL_HI 15
`define PLPS_SEL_LO 14
`define PLPS_TICK_HI 13
`define PLPS_TICK_LO 8
`define PLPS_PAT_HI 7
`define PLPS_PAT_LO 0
`define PLPS_POL_SECOND 11
`define PLPS_POL_FIRST 10
`define PLPS_STATUS_RSVD_LO 10'h3FC

`define PLPS_TICK_SPECIAL 6'h3F
`define PLPS_TICK_STEP_MS 8
`define PLPS_SHORT_TICK_MS 1
`define PLPS_MS_IN_NS 1000000
`define PLPS_CLK_PERIOD_NS 8

`endif

// ---- logic/plps_tick_timer.v ----
// reloadable down-counter that emits one pulse per programmed period
module plps_tick_timer
#(
    parameter CNT_W = 32
)
(
    input wire clk,
    input wire arst_n,
    input wire restart,
    input wire [CNT_W-1:0] period,
    output reg tick
);

reg [CNT_W-1:0] count;
reg armed;

// period is sampled at each reload, so a new length applies from the next tick
// first load after reset takes the period, else bit 0 would last one cycle
always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        count <= {CNT_W{1'b0}};
        armed <= 1'b0;
        tick <= 1'b0;
    end
    else if (restart || !armed)
    begin
        count <= period - {{(CNT_W-1){1'b0}}, 1'b1};
        armed <= 1'b1;
        tick <= 1'b0;
    end
    else if (count == {CNT_W{1'b0}})
    begin
        count <= period - {{(CNT_W-1){1'b0}}, 1'b1};
        tick <= 1'b1;
    end
    else
    begin
        count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
        tick <= 1'b0;
    end
end

endmodule

// ---- logic/plps_top.v ----
// indicator blink, polarity status and low-power capability registers on Avalon-MM
`include "plps_regs.vh"

module plps_top
#(
    parameter MS_CYCLES = `PLPS_MS_IN_NS / `PLPS_CLK_PERIOD_NS,
    parameter GAP_W = 8
)
(
    input wire clk,
    input wire arst_n,
    input wire [17:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire first_pair_polarity_flipped,
    input wire second_pair_polarity_flipped,
    output reg first_indicator_output
);

localparam CNT_W = 32;
localparam [1:0] ST_SHOW = 2'b01;
localparam [1:0] ST_GAP = 2'b10;
localparam [CNT_W-1:0] MS_CNT = MS_CYCLES;
localparam [15:0] BLINK_RST = `PLPS_BLINK_RESET;

function reg_hit;
    input [17:0] addr;
    input [15:0] idx;
    begin
        reg_hit = (addr == {idx, 2'b00});
    end
endfunction

// ---- register storage
reg [5:0] blink_tick_length;
reg [7:0] blink_bit_sequence;
reg [GAP_W-1:0] blink_gap_length;

// ---- bus handshake
wire req = avs_read | avs_write;
wire wr_take = avs_write & ~avs_waitrequest;
wire hit_blink = reg_hit(avs_address, `PLPS_IDX_BLINK);
wire hit_status = reg_hit(avs_address, `PLPS_IDX_STATUS);
wire hit_cap = reg_hit(avs_address, `PLPS_IDX_CAP);
wire hit_gap = reg_hit(avs_address, `PLPS_IDX_GAP);

// one wait cycle, then a single-cycle answer; the master releases after it
reg next_waitrequest;

always @*
begin
    next_waitrequest = 1'b1;
    if (req && avs_waitrequest)
    begin
        next_waitrequest = 1'b0;
    end
end

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        avs_waitrequest <= 1'b1;
    end
    else
    begin
        avs_waitrequest <= next_waitrequest;
    end
end

// ---- polarity status synchronisers
wire [1:0] pol_pin;
wire [1:0] pol_state;
assign pol_pin[0] = first_pair_polarity_flipped;
assign pol_pin[1] = second_pair_polarity_flipped;

genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : pol_sync
        reg [2:0] pipe;
        reg settled;
        always @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                pipe <= 3'b000;
                settled <= 1'b0;
            end
            else
            begin
                pipe <= {pipe[1:0], pol_pin[g]};
                // first stage only feeds the second; stages two and three must agree
                if (pipe[1] == pipe[2])
                begin
                    settled <= pipe[2];
                end
            end
        end
        assign pol_state[g] = settled;
    end
endgenerate

// ---- read data assembly
reg [15:0] next_rdata;

always @*
begin
    next_rdata = 16'h0000;
    if (hit_blink)
    begin
        next_rdata[`PLPS_SEL_HI:`PLPS_SEL_LO] = 2'b00;
        next_rdata[`PLPS_TICK_HI:`PLPS_TICK_LO] = blink_tick_length;
        next_rdata[`PLPS_PAT_HI:`PLPS_PAT_LO] = blink_bit_sequence;
    end
    else if (hit_status)
    begin
        next_rdata[9:0] = `PLPS_STATUS_RSVD_LO;
        next_rdata[`PLPS_POL_SECOND] = pol_state[1];
        next_rdata[`PLPS_POL_FIRST] = pol_state[0];
    end
    else if (hit_cap)
    begin
        next_rdata = `PLPS_CAP_VALUE;
    end
    else if (hit_gap)
    begin
        next_rdata[GAP_W-1:0] = blink_gap_length;
    end
    else
    begin
        next_rdata = 16'h0000;
    end
end

// read data registered as waitrequest drops, held until the next read
reg [31:0] next_readdata;

always @*
begin
    next_readdata = avs_readdata;
    if (avs_read && avs_waitrequest)
    begin
        next_readdata = {16'h0000, next_rdata};
    end
end

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        avs_readdata <= 32'h00000000;
    end
    else
    begin
        avs_readdata <= next_readdata;
    end
end

// ---- register writes
reg cfg_written;
reg [5:0] next_blink_tick_length;
reg [7:0] next_blink_bit_sequence;
reg [GAP_W-1:0] next_blink_gap_length;
reg next_cfg_written;

// status and capability have no write path; the select field is never stored
always @*
begin
    next_blink_tick_length = blink_tick_length;
    next_blink_bit_sequence = blink_bit_sequence;
    next_blink_gap_length = blink_gap_length;
    next_cfg_written = 1'b0;
    if (wr_take && hit_blink)
    begin
        if (avs_byteenable[0])
        begin
            next_blink_bit_sequence = avs_writedata[`PLPS_PAT_HI:`PLPS_PAT_LO];
        end
        if (avs_byteenable[1])
        begin
            next_blink_tick_length = avs_writedata[`PLPS_TICK_HI:`PLPS_TICK_LO];
        end
        next_cfg_written = 1'b1;
    end
    else if (wr_take && hit_gap)
    begin
        if (avs_byteenable[0])
        begin
            next_blink_gap_length = avs_writedata[GAP_W-1:0];
        end
        next_cfg_written = 1'b1;
    end
end

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        blink_tick_length <= BLINK_RST[`PLPS_TICK_HI:`PLPS_TICK_LO];
        blink_bit_sequence <= BLINK_RST[`PLPS_PAT_HI:`PLPS_PAT_LO];
        blink_gap_length <= `PLPS_GAP_RESET;
        cfg_written <= 1'b0;
    end
    else
    begin
        blink_tick_length <= next_blink_tick_length;
        blink_bit_sequence <= next_blink_bit_sequence;
        blink_gap_length <= next_blink_gap_length;
        cfg_written <= next_cfg_written;
    end
end

// ---- tick length
reg [CNT_W-1:0] tick_cycles;
reg [CNT_W-1:0] tick_mult;

always @*
begin
    tick_mult = {{(CNT_W-6){1'b0}}, blink_tick_length} + {{(CNT_W-1){1'b0}}, 1'b1};
    if (blink_tick_length == `PLPS_TICK_SPECIAL)
    begin
        tick_cycles = MS_CNT * `PLPS_SHORT_TICK_MS;
    end
    else
    begin
        tick_cycles = tick_mult * `PLPS_TICK_STEP_MS * MS_CNT;
    end
end

wire tick;

plps_tick_timer #(
    .CNT_W(CNT_W)
) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .restart(cfg_written),
    .period(tick_cycles),
    .tick(tick)
);

// ---- pattern sequencer
reg [1:0] state;
reg [2:0] bit_idx;
reg [GAP_W-1:0] gap_left;
reg [1:0] next_state;
reg [2:0] next_bit_idx;
reg [GAP_W-1:0] next_gap_left;

// a blink or gap write restarts the pattern from bit 0 so the new settings show at once
always @*
begin
    next_state = state;
    next_bit_idx = bit_idx;
    next_gap_left = gap_left;
    if (cfg_written)
    begin
        next_state = ST_SHOW;
        next_bit_idx = 3'h0;
        next_gap_left = {GAP_W{1'b0}};
    end
    else if (tick)
    begin
        case (state)
            ST_SHOW:
            begin
                if (bit_idx == 3'h7)
                begin
                    next_bit_idx = 3'h0;
                    if (blink_gap_length != {GAP_W{1'b0}})
                    begin
                        next_state = ST_GAP;
                        next_gap_left = blink_gap_length;
                    end
                end
                else
                begin
                    next_bit_idx = bit_idx + 3'h1;
                end
            end
            ST_GAP:
            begin
                if (gap_left == {{(GAP_W-1){1'b0}}, 1'b1})
                begin
                    next_state = ST_SHOW;
                    next_gap_left = {GAP_W{1'b0}};
                end
                else
                begin
                    next_gap_left = gap_left - {{(GAP_W-1){1'b0}}, 1'b1};
                end
            end
            default:
            begin
                next_state = ST_SHOW;
                next_bit_idx = 3'h0;
            end
        endcase
    end
end

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        state <= ST_SHOW;
        bit_idx <= 3'h0;
        gap_left <= {GAP_W{1'b0}};
    end
    else
    begin
        state <= next_state;
        bit_idx <= next_bit_idx;
        gap_left <= next_gap_left;
    end
end

// indicator is dark during the gap
reg next_indicator;

always @*
begin
    next_indicator = 1'b0;
    if (state == ST_SHOW)
    begin
        next_indicator = blink_bit_sequence[bit_idx];
    end
end

always @(posedge clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        first_indicator_output <= 1'b0;
    end
    else
    begin
        first_indicator_output <= next_indicator;
    end
end

endmodule

// ---- sim/plps_chk_sva.sv ----
// assertion checker for the blink, polarity and capability registers
module plps_chk
#(
    parameter MS_CYCLES = 4
)
(
    input wire clk,
    input wire arst_n,
    input wire [17:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire first_pair_polarity_flipped,
    input wire second_pair_polarity_flipped,
    input wire first_indicator_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic prev;
    int run;
    logic [2:0] wr_age;
    // a blink or gap write restarts the pattern, so changes just after any write are exempt
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
        begin
            prev <= 1'b0;
            run <= 0;
            wr_age <= 3'h0;
        end
        else
        begin
            prev <= first_indicator_output;
            run <= (first_indicator_output != prev) ? 1 : run + 1;
            wr_age <= (avs_write && !avs_waitrequest) ? 3'h0 : wr_age + {2'h0, wr_age != 3'h7};
        end
    sequence s_rd(a);
        avs_read && avs_waitrequest && avs_address == a;
    endsequence
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    a_cap_const: assert property (s_rd(18'h20000) |=> avs_readdata == 32'h00000006)
        else $error("capability read wrong");
    a_sel_zero: assert property (s_rd(18'h00074) |=> avs_readdata[15:14] == 2'h0)
        else $error("bank select not zero");
    a_status_rsvd: assert property (s_rd(18'h0007C) |=> avs_readdata[9:0] == 10'h3FC)
        else $error("status reserved bits wrong");
    a_pol_first: assert property (
        $stable(first_pair_polarity_flipped)[*8] ##0 s_rd(18'h0007C)
        |=> avs_readdata[10] == $past(first_pair_polarity_flipped))
        else $error("first pair polarity bit wrong");
    a_pol_second: assert property (
        $stable(second_pair_polarity_flipped)[*8] ##0 s_rd(18'h0007C)
        |=> avs_readdata[11] == $past(second_pair_polarity_flipped))
        else $error("second pair polarity bit wrong");
    a_tick_min: assert property ((first_indicator_output != prev) && wr_age == 3'h7
        |-> run >= MS_CYCLES)
        else $error("indicator bit shorter than one tick");
endmodule

bind plps_top plps_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .first_pair_polarity_flipped(first_pair_polarity_flipped),
    .second_pair_polarity_flipped(second_pair_polarity_flipped),
    .first_indicator_output(first_indicator_output));

// ---- sim/test_phy_led_pattern_status_regs.sv ----
// self-checking bench for the blink, polarity and capability registers
module test_phy_led_pattern_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 8;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [17:0] avs_address = 18'h00000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pol0 = 1'b0;
    logic pol1 = 1'b0;
    logic ind;
    int n_mismatch = 0;
    int compares = 0;
    int ctl = 16'h1855;
    int gap = 0;
    logic [31:0] q;
    logic [17:0] regs [5] = '{18'h00074, 18'h0007C, 18'h20000, 18'h00400, 18'h00040};
    always #4 clk = ~clk;
    plps_top #(.MS_CYCLES(MS)) DUT (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .first_pair_polarity_flipped(pol0),
        .second_pair_polarity_flipped(pol1), .first_indicator_output(ind));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [17:0] a, input logic [15:0] d,
        input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    function automatic logic [31:0] model(input logic [17:0] a);
        case (a)
            18'h00074: return ctl;
            18'h0007C: return {pol1, pol0, 10'h3FC};
            18'h20000: return 32'h00000006;
            18'h00400: return gap;
            default: return 32'h00000000;
        endcase
    endfunction
    task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
        if (a == 18'h00074)
            ctl = {2'h0, be[1] ? d[13:8] : ctl[13:8], be[0] ? d[7:0] : ctl[7:0]};
        if (a == 18'h00400 && be[0])
            gap = d[7:0];
    endtask
    task automatic rd(input logic [17:0] a);
        bus(1'b0, a, 16'h0000, 4'hF);
        chk(q, model(a));
    endtask
    // samples mid-bit, so the one-cycle timer load never lands on a sample
    task automatic blink(input int tick);
        int t;
        int k;
        logic [7:0] p;
        p = 8'($urandom);
        t = (tick == 63) ? MS : (tick + 1) * 8 * MS;
        wr(18'h00074, {2'h0, 6'(tick), p}, 4'h3);
        repeat (2 + t / 2) @(posedge clk);
        for (int i = 0; i < 11; i++)
        begin
            k = i % (8 + gap);
            #1 chk(32'(ind), 32'(k < 8 ? p[k] : 1'b0));
            repeat (t) @(posedge clk);
        end
    endtask
    task automatic end_of_test;
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        end_of_test;
    end
    initial
    begin
        void'($urandom(23742));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        foreach (regs[i]) rd(regs[i]);
        $display("test reset values done");
        foreach (regs[i])
        begin
            wr(regs[i], 16'hFFFF, 4'hF);
            rd(regs[i]);
        end
        wr(18'h00074, 16'($urandom), 4'h1);
        rd(18'h00074);
        $display("test writes done");
        for (int v = 0; v < 4; v++)
        begin
            pol0 <= v[0];
            pol1 <= v[1];
            repeat (8) @(posedge clk);
            rd(18'h0007C);
        end
        $display("test polarity done");
        for (int j = 0; j < 3; j++)
        begin
            wr(18'h00400, 16'(j), 4'h1);
            blink(j == 0 ? 63 : j - 1);
        end
        $display("test blink done");
        end_of_test;
    end
endmodule
